/* File: hw/sdio_slot_io.sv */
`timescale 1ns/10ps
module sdio_slot_io #(
	parameter int GATE_CYCLES = sdio_pkg::GATE_CYCLES
) (
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire logic               clk_en,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [7:0]         paddr,
	input  wire logic [31:0]        pwdata,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	input  wire logic               slot_input_a,
	input  wire logic               slot_input_b,
	output logic                    slot_input_a_level,
	output logic                    slot_input_b_level,
	output logic signed [15:0]      freq_input_a,
	output logic signed [15:0]      freq_input_b,
	output logic                    slot_output_a,
	output logic                    slot_output_b,
	input  wire logic               freq_wave_a,
	input  wire logic               freq_wave_b,
	input  wire logic signed [15:0] speed_ref,
	input  wire logic signed [15:0] motor_speed,
	input  wire logic [15:0]        motor_freq,
	input  wire logic [15:0]        output_current,
	input  wire logic signed [15:0] motor_torque,
	input  wire logic [31:0]        enabled_hours,
	input  wire logic [1:0]         cmd_source,
	input  wire logic               drive_run,
	input  wire logic               drive_ready,
	input  wire logic               safe_torque_off_state,
	input  wire logic               fault_present,
	input  wire logic               alarm_present,
	input  wire logic               net_cmd_a,
	input  wire logic               net_cmd_b,
	input  wire logic               plc_cmd_a,
	input  wire logic               plc_cmd_b,
	input  wire logic               forward_dir,
	input  wire logic               ride_through_active,
	input  wire logic               precharge_ok
);
	localparam int GW = $clog2(GATE_CYCLES + 1);

	logic [1:0]         in_pin;
	logic [1:0]         wave;
	logic [1:0]         net_cmd;
	logic [1:0]         plc_cmd;
	logic [1:0]         sync1;
	logic [1:0]         sync2;
	logic [1:0]         prev_lvl;
	logic [1:0]         lvl;
	logic [1:0]         out_pin;
	logic [1:0]         in_mode   [2];
	logic [15:0]        fmin      [2];
	logic [15:0]        fmax      [2];
	logic [13:0]        gain      [2];
	logic signed [15:0] offs      [2];
	logic [15:0]        edge_cnt  [2];
	logic [15:0]        meas_hz   [2];
	logic signed [15:0] scaled    [2];
	logic               out_mode  [2];
	logic [4:0]         out_func  [2];
	logic [3:0]         ch_hit;
	logic [3:0]         ch_bad;
	logic [31:0]        ch_rdata  [4];
	logic signed [15:0] speed_thr_x;
	logic signed [15:0] speed_thr_y;
	logic [15:0]        freq_thr;
	logic [15:0]        curr_thr;
	logic signed [15:0] torq_thr;
	logic [31:0]        hours_thr;
	logic [GW-1:0]      gate_cnt;
	logic               gate_tick;
	logic               setup;
	logic               wr_en;
	logic               g_hit;
	logic [31:0]        g_rdata;
	logic [31:0]        next_rdata;
	logic               any_hit;
	logic               any_bad;

	assign in_pin  = {slot_input_b, slot_input_a};
	assign wave    = {freq_wave_b, freq_wave_a};
	assign net_cmd = {net_cmd_b, net_cmd_a};
	assign plc_cmd = {plc_cmd_b, plc_cmd_a};

	// Zero wait states; a frozen block must also stall the bus
	assign pready = clk_en;
	assign setup  = psel & ~penable & clk_en;
	assign wr_en  = psel & penable & pwrite & clk_en;

	// Shared measurement gate for both inputs
	assign gate_tick = (gate_cnt == GW'(GATE_CYCLES - 1));
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gate_cnt <= '0;
		end else if (clk_en) begin
			gate_cnt <= gate_tick ? '0 : gate_cnt + 1'b1;
		end
	end

	// Function select for an on/off output
	function automatic logic fn_active(input logic [4:0] code, input logic net,
			input logic plc);
		logic act;
		act = 1'b0;
		unique case (code)
			sdio_pkg::FN_OFF:       act = 1'b0;
			sdio_pkg::FN_ON:        act = 1'b1;
			sdio_pkg::FN_REF_GT_X:  act = speed_ref > speed_thr_x;
			sdio_pkg::FN_SPD_GT_X:  act = motor_speed > speed_thr_x;
			sdio_pkg::FN_SPD_LT_Y:  act = motor_speed < speed_thr_y;
			sdio_pkg::FN_SPD_EQ:    act = motor_speed == speed_ref;
			sdio_pkg::FN_FREQ_GT:   act = motor_freq > freq_thr;
			sdio_pkg::FN_CUR_GT:    act = output_current > curr_thr;
			sdio_pkg::FN_CUR_LT:    act = output_current < curr_thr;
			sdio_pkg::FN_TRQ_GT:    act = motor_torque > torq_thr;
			sdio_pkg::FN_TRQ_LT:    act = motor_torque < torq_thr;
			sdio_pkg::FN_HOURS_GT:  act = enabled_hours > hours_thr;
			sdio_pkg::FN_LOCAL:     act = cmd_source == sdio_pkg::SRC_LOCAL;
			sdio_pkg::FN_REMOTE1:   act = cmd_source == sdio_pkg::SRC_REMOTE1;
			sdio_pkg::FN_REMOTE2:   act = cmd_source == sdio_pkg::SRC_REMOTE2;
			sdio_pkg::FN_RUN:       act = drive_run;
			sdio_pkg::FN_READY:     act = drive_ready;
			sdio_pkg::FN_STO:       act = safe_torque_off_state;
			sdio_pkg::FN_NO_FAULT:  act = ~fault_present;
			sdio_pkg::FN_FAULT:     act = fault_present;
			sdio_pkg::FN_NO_ALARM:  act = ~alarm_present;
			sdio_pkg::FN_HEALTHY:   act = ~fault_present & ~alarm_present;
			sdio_pkg::FN_NETWORK:   act = net;
			sdio_pkg::FN_PROGRAM:   act = plc;
			sdio_pkg::FN_FORWARD:   act = forward_dir;
			sdio_pkg::FN_RIDE:      act = ride_through_active;
			sdio_pkg::FN_PRECHARGE: act = precharge_ok;
			default:                act = 1'b0;
		endcase
		return act;
	endfunction : fn_active

	genvar c;
	generate
		for (c = 0; c < 2; c++) begin : g_in
			localparam logic [7:0] IB = 8'(sdio_pkg::ADDR_IN_BASE + c * sdio_pkg::ADDR_IN_STRIDE);
			logic        rising;
			logic        counting;
			logic signed [31:0] wsig;

			assign rising   = sync2[c] & ~prev_lvl[c];
			assign counting = (in_mode[c] == sdio_pkg::IN_MODE_FREQ) ||
				(in_mode[c] == sdio_pkg::IN_MODE_ENC);
			assign wsig     = signed'(pwdata);

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					sync1[c]    <= 1'b0;
					sync2[c]    <= 1'b0;
					prev_lvl[c] <= 1'b0;
					lvl[c]      <= 1'b0;
				end else if (clk_en) begin
					sync1[c]    <= in_pin[c];
					sync2[c]    <= sync1[c];
					prev_lvl[c] <= sync2[c];
					// Polled level only in mode 0, so a frequency input drives no command
					lvl[c]      <= (in_mode[c] == sdio_pkg::IN_MODE_POLL) & sync2[c];
				end
			end

			// Edges per gate window, scaled to Hz at the window's end
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					edge_cnt[c] <= '0;
					meas_hz[c]  <= '0;
				end else if (clk_en) begin
					if (gate_tick) begin
						edge_cnt[c] <= 16'(rising & counting);
						meas_hz[c]  <= counting ?
							16'(edge_cnt[c] * sdio_pkg::HZ_PER_COUNT) : '0;
					end else if (rising && counting && edge_cnt[c] != '1) begin
						edge_cnt[c] <= edge_cnt[c] + 1'b1;
					end
				end
			end

			always_comb begin
				ch_bad[c] = 1'b0;
				if (paddr == IB + sdio_pkg::IN_FMIN_OFS || paddr == IB + sdio_pkg::IN_FMAX_OFS)
					ch_bad[c] = pwdata > 32'(sdio_pkg::FREQ_LIMIT);
				else if (paddr == IB + sdio_pkg::IN_GAIN_OFS)
					ch_bad[c] = pwdata > 32'(sdio_pkg::GAIN_LIMIT);
				else if (paddr == IB + sdio_pkg::IN_OFFSET_OFS)
					ch_bad[c] = wsig > signed'(32'(sdio_pkg::PCT_FULL)) ||
						wsig < -signed'(32'(sdio_pkg::PCT_FULL));
			end

			// Out-of-range writes keep the old value
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					in_mode[c] <= sdio_pkg::IN_MODE_POLL;
					fmin[c]    <= sdio_pkg::FMIN_RST;
					fmax[c]    <= sdio_pkg::FMAX_RST;
					gain[c]    <= sdio_pkg::GAIN_RST;
					offs[c]    <= sdio_pkg::OFFSET_RST;
				end else if (wr_en && !ch_bad[c]) begin
					if (paddr == IB + sdio_pkg::IN_MODE_OFS)
						in_mode[c] <= pwdata[1:0];
					if (paddr == IB + sdio_pkg::IN_FMIN_OFS)
						fmin[c] <= pwdata[15:0];
					if (paddr == IB + sdio_pkg::IN_FMAX_OFS)
						fmax[c] <= pwdata[15:0];
					if (paddr == IB + sdio_pkg::IN_GAIN_OFS)
						gain[c] <= pwdata[13:0];
					if (paddr == IB + sdio_pkg::IN_OFFSET_OFS)
						offs[c] <= pwdata[15:0];
				end
			end

			always_comb begin
				ch_hit[c]   = 1'b1;
				ch_rdata[c] = '0;
				unique case (paddr)
					IB + sdio_pkg::IN_MODE_OFS:   ch_rdata[c] = 32'(in_mode[c]);
					IB + sdio_pkg::IN_FMIN_OFS:   ch_rdata[c] = 32'(fmin[c]);
					IB + sdio_pkg::IN_FMAX_OFS:   ch_rdata[c] = 32'(fmax[c]);
					IB + sdio_pkg::IN_GAIN_OFS:   ch_rdata[c] = 32'(gain[c]);
					IB + sdio_pkg::IN_OFFSET_OFS: ch_rdata[c] = 32'(offs[c]);
					IB + sdio_pkg::IN_MEAS_OFS:   ch_rdata[c] = 32'(meas_hz[c]);
					IB + sdio_pkg::IN_SCALED_OFS: ch_rdata[c] = 32'(scaled[c]);
					default:                      ch_hit[c]   = 1'b0;
				endcase
			end
		end

		for (c = 0; c < 2; c++) begin : g_out
			localparam logic [7:0] OB = 8'(sdio_pkg::ADDR_OUT_BASE + c * sdio_pkg::ADDR_OUT_STRIDE);

			assign ch_bad[c+2] = (paddr == OB + sdio_pkg::OUT_FUNC_OFS) &&
				(pwdata > 32'(sdio_pkg::FUNC_LIMIT));

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					out_mode[c] <= 1'b0;
					out_func[c] <= (c == 0) ? sdio_pkg::FUNC_A_RST : sdio_pkg::FUNC_B_RST;
				end else if (wr_en && !ch_bad[c+2]) begin
					if (paddr == OB + sdio_pkg::OUT_MODE_OFS)
						out_mode[c] <= pwdata[0];
					if (paddr == OB + sdio_pkg::OUT_FUNC_OFS)
						out_func[c] <= pwdata[4:0];
				end
			end

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					out_pin[c] <= 1'b0;
				end else if (clk_en) begin
					out_pin[c] <= (out_mode[c] == sdio_pkg::OUT_MODE_FREQ) ? wave[c] :
						fn_active(out_func[c], net_cmd[c], plc_cmd[c]);
				end
			end

			always_comb begin
				ch_hit[c+2]   = 1'b1;
				ch_rdata[c+2] = '0;
				unique case (paddr)
					OB + sdio_pkg::OUT_MODE_OFS: ch_rdata[c+2] = 32'(out_mode[c]);
					OB + sdio_pkg::OUT_FUNC_OFS: ch_rdata[c+2] = 32'(out_func[c]);
					default:                     ch_hit[c+2]   = 1'b0;
				endcase
			end
		end
	endgenerate

	// One divider serves both inputs in turn; 32 cycles per update is far below the gate time
	sdio_pkg::sdio_div_state_t dv_state;
	logic               dv_ch;
	logic [29:0]        quo;
	logic [16:0]        rem;
	logic [15:0]        den;
	logic [4:0]         steps;
	logic [15:0]        fclamp;
	logic [16:0]        rem_sh;
	logic [27:0]        prod;
	logic signed [19:0] sum;
	logic signed [15:0] sat;

	always_comb begin
		fclamp = meas_hz[dv_ch];
		if (fclamp < fmin[dv_ch])
			fclamp = fmin[dv_ch];
		else if (fclamp > fmax[dv_ch])
			fclamp = fmax[dv_ch];
	end

	assign rem_sh = {rem[15:0], quo[29]};
	assign prod   = 28'(quo[13:0] * gain[dv_ch]);
	assign sum    = signed'({1'b0, 19'(prod / sdio_pkg::GAIN_UNITY)}) + 20'(offs[dv_ch]);

	always_comb begin
		if (sum > signed'(20'(sdio_pkg::PCT_FULL)))
			sat = signed'(sdio_pkg::PCT_FULL);
		else if (sum < -signed'(20'(sdio_pkg::PCT_FULL)))
			sat = -signed'(sdio_pkg::PCT_FULL);
		else
			sat = 16'(sum);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dv_state <= sdio_pkg::SDIO_DV_LOAD;
			dv_ch    <= 1'b0;
			quo      <= '0;
			rem      <= '0;
			den      <= '0;
			steps    <= '0;
		end else if (clk_en) begin
			unique case (dv_state)
				sdio_pkg::SDIO_DV_LOAD: begin
					rem   <= '0;
					den   <= fmax[dv_ch] - fmin[dv_ch];
					steps <= sdio_pkg::DIV_STEPS;
					if (fmax[dv_ch] <= fmin[dv_ch]) begin
						// No usable span: position reads as zero
						quo      <= '0;
						dv_state <= sdio_pkg::SDIO_DV_DONE;
					end else begin
						quo      <= 30'((fclamp - fmin[dv_ch]) * sdio_pkg::PCT_FULL);
						dv_state <= sdio_pkg::SDIO_DV_RUN;
					end
				end
				sdio_pkg::SDIO_DV_RUN: begin
					if (rem_sh >= {1'b0, den}) begin
						rem <= rem_sh - {1'b0, den};
						quo <= {quo[28:0], 1'b1};
					end else begin
						rem <= rem_sh;
						quo <= {quo[28:0], 1'b0};
					end
					steps <= steps - 1'b1;
					if (steps == 5'h01)
						dv_state <= sdio_pkg::SDIO_DV_DONE;
				end
				sdio_pkg::SDIO_DV_DONE: begin
					dv_ch    <= ~dv_ch;
					dv_state <= sdio_pkg::SDIO_DV_LOAD;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scaled[0] <= '0;
			scaled[1] <= '0;
		end else if (clk_en && dv_state == sdio_pkg::SDIO_DV_DONE) begin
			scaled[dv_ch] <= (in_mode[dv_ch] == sdio_pkg::IN_MODE_FREQ) ? sat : '0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			speed_thr_x <= '0;
			speed_thr_y <= '0;
			freq_thr    <= '0;
			curr_thr    <= '0;
			torq_thr    <= '0;
			hours_thr   <= '0;
		end else if (wr_en) begin
			unique case (paddr)
				sdio_pkg::ADDR_SPEED_X:   speed_thr_x <= pwdata[15:0];
				sdio_pkg::ADDR_SPEED_Y:   speed_thr_y <= pwdata[15:0];
				sdio_pkg::ADDR_FREQ_THR:  freq_thr    <= pwdata[15:0];
				sdio_pkg::ADDR_CURR_THR:  curr_thr    <= pwdata[15:0];
				sdio_pkg::ADDR_TORQ_THR:  torq_thr    <= pwdata[15:0];
				sdio_pkg::ADDR_HOURS_THR: hours_thr   <= pwdata;
				default: ;
			endcase
		end
	end

	always_comb begin
		g_hit   = 1'b1;
		g_rdata = '0;
		unique case (paddr)
			sdio_pkg::ADDR_SPEED_X:   g_rdata = 32'(speed_thr_x);
			sdio_pkg::ADDR_SPEED_Y:   g_rdata = 32'(speed_thr_y);
			sdio_pkg::ADDR_FREQ_THR:  g_rdata = 32'(freq_thr);
			sdio_pkg::ADDR_CURR_THR:  g_rdata = 32'(curr_thr);
			sdio_pkg::ADDR_TORQ_THR:  g_rdata = 32'(torq_thr);
			sdio_pkg::ADDR_HOURS_THR: g_rdata = hours_thr;
			sdio_pkg::ADDR_STATUS:    g_rdata = 32'({out_pin, sync2});
			default:                  g_hit   = 1'b0;
		endcase
	end

	always_comb begin
		next_rdata = g_rdata;
		for (int i = 0; i < 4; i++)
			next_rdata = next_rdata | ch_rdata[i];
	end

	assign any_hit = g_hit | (|ch_hit);
	assign any_bad = |ch_bad;
	assign pslverr = psel & penable & clk_en & (~any_hit | (pwrite & any_bad));

	// Read data captured in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (setup) begin
			prdata <= pwrite ? '0 : next_rdata;
		end
	end

	assign slot_input_a_level = lvl[0];
	assign slot_input_b_level = lvl[1];
	assign freq_input_a       = scaled[0];
	assign freq_input_b       = scaled[1];
	assign slot_output_a      = out_pin[0];
	assign slot_output_b      = out_pin[1];
endmodule : sdio_slot_io

/* File: inc/sdio_pkg.sv */
// What this block does
// - Input mode: 0 polled level, 1 unused, 2 frequency input, 3 encoder frequency.
// - Zero-scale frequency 0..32000 Hz, reset 0 Hz, means zero percent.
// - Full-scale frequency 0..32000 Hz, reset 32000 Hz, means hundred percent.
// - Gain 0.000..9.999, reset 1.000, multiplies the scaled value.
// - Offset -100.00..+100.00 % in hundredths, reset 0.00 %, added to scaled value.
// - Output mode: 0 on/off from selected function, 1 frequency output.
// - Output function code 0..30; output a resets to 22, output b to 19.
// - Code 0 keeps output inactive, code 1 keeps it active.
// - Codes 2..5: reference above X, speed above X, speed below Y, speed equals reference.
// - Code 8 active while motor frequency exceeds frequency threshold.
// - Code 9 current above threshold, code 10 current below threshold.
// - Code 11 torque above threshold, code 12 torque below threshold.
// - Code 13 active while enabled hours exceed hours threshold.
// - Codes 16..18 active for local, remote one, remote two command source.
// - Codes 19..21 active in run, ready, safe torque off state.
// - Code 22 active without fault, code 23 active with any fault.
// - Code 24 active without alarm, code 25 without fault and without alarm.
// - Code 26 follows network command bit, code 27 follows logic-program command bit.
// - Codes 28..30: forward running, ride-through acting, precharge completed.
package sdio_pkg;
	localparam int CLK_HZ       = 250_000_000;
	localparam int GATE_TIME_MS = 100;
	localparam int MS_PER_S     = 1000;
	localparam int GATE_CYCLES  = CLK_HZ / MS_PER_S * GATE_TIME_MS;
	localparam int HZ_PER_COUNT = MS_PER_S / GATE_TIME_MS;

	localparam logic [15:0] FREQ_LIMIT  = 16'h7d00;
	localparam logic [15:0] FMIN_RST    = 16'h0000;
	localparam logic [15:0] FMAX_RST    = 16'h7d00;
	localparam logic [13:0] GAIN_LIMIT  = 14'h270f;
	localparam logic [13:0] GAIN_RST    = 14'h03e8;
	localparam int          GAIN_UNITY  = 1000;
	localparam logic [15:0] PCT_FULL    = 16'h2710;
	localparam logic [15:0] OFFSET_RST  = 16'h0000;
	localparam logic [4:0]  FUNC_LIMIT  = 5'h1e;
	localparam logic [4:0]  FUNC_A_RST  = 5'h16;
	localparam logic [4:0]  FUNC_B_RST  = 5'h13;
	localparam logic [4:0]  DIV_STEPS   = 5'h1e;

	localparam logic [1:0] IN_MODE_POLL = 2'h0;
	localparam logic [1:0] IN_MODE_FREQ = 2'h2;
	localparam logic [1:0] IN_MODE_ENC  = 2'h3;
	localparam logic       OUT_MODE_FREQ = 1'b1;

	localparam logic [1:0] SRC_LOCAL   = 2'h0;
	localparam logic [1:0] SRC_REMOTE1 = 2'h1;
	localparam logic [1:0] SRC_REMOTE2 = 2'h2;

	localparam logic [4:0] FN_OFF       = 5'h00;
	localparam logic [4:0] FN_ON        = 5'h01;
	localparam logic [4:0] FN_REF_GT_X  = 5'h02;
	localparam logic [4:0] FN_SPD_GT_X  = 5'h03;
	localparam logic [4:0] FN_SPD_LT_Y  = 5'h04;
	localparam logic [4:0] FN_SPD_EQ    = 5'h05;
	localparam logic [4:0] FN_FREQ_GT   = 5'h08;
	localparam logic [4:0] FN_CUR_GT    = 5'h09;
	localparam logic [4:0] FN_CUR_LT    = 5'h0a;
	localparam logic [4:0] FN_TRQ_GT    = 5'h0b;
	localparam logic [4:0] FN_TRQ_LT    = 5'h0c;
	localparam logic [4:0] FN_HOURS_GT  = 5'h0d;
	localparam logic [4:0] FN_LOCAL     = 5'h10;
	localparam logic [4:0] FN_REMOTE1   = 5'h11;
	localparam logic [4:0] FN_REMOTE2   = 5'h12;
	localparam logic [4:0] FN_RUN       = 5'h13;
	localparam logic [4:0] FN_READY     = 5'h14;
	localparam logic [4:0] FN_STO       = 5'h15;
	localparam logic [4:0] FN_NO_FAULT  = 5'h16;
	localparam logic [4:0] FN_FAULT     = 5'h17;
	localparam logic [4:0] FN_NO_ALARM  = 5'h18;
	localparam logic [4:0] FN_HEALTHY   = 5'h19;
	localparam logic [4:0] FN_NETWORK   = 5'h1a;
	localparam logic [4:0] FN_PROGRAM   = 5'h1b;
	localparam logic [4:0] FN_FORWARD   = 5'h1c;
	localparam logic [4:0] FN_RIDE      = 5'h1d;
	localparam logic [4:0] FN_PRECHARGE = 5'h1e;

	localparam int         ADDR_IN_BASE   = 'h00;
	localparam int         ADDR_IN_STRIDE = 'h20;
	localparam logic [7:0] IN_MODE_OFS    = 8'h00;
	localparam logic [7:0] IN_FMIN_OFS    = 8'h04;
	localparam logic [7:0] IN_FMAX_OFS    = 8'h08;
	localparam logic [7:0] IN_GAIN_OFS    = 8'h0c;
	localparam logic [7:0] IN_OFFSET_OFS  = 8'h10;
	localparam logic [7:0] IN_MEAS_OFS    = 8'h14;
	localparam logic [7:0] IN_SCALED_OFS  = 8'h18;
	localparam int         ADDR_OUT_BASE   = 'h40;
	localparam int         ADDR_OUT_STRIDE = 'h10;
	localparam logic [7:0] OUT_MODE_OFS    = 8'h00;
	localparam logic [7:0] OUT_FUNC_OFS    = 8'h04;
	localparam logic [7:0] ADDR_SPEED_X    = 8'h60;
	localparam logic [7:0] ADDR_SPEED_Y    = 8'h64;
	localparam logic [7:0] ADDR_FREQ_THR   = 8'h68;
	localparam logic [7:0] ADDR_CURR_THR   = 8'h6c;
	localparam logic [7:0] ADDR_TORQ_THR   = 8'h70;
	localparam logic [7:0] ADDR_HOURS_THR  = 8'h74;
	localparam logic [7:0] ADDR_STATUS     = 8'h78;

	typedef enum logic [1:0] {
		SDIO_DV_LOAD,
		SDIO_DV_RUN,
		SDIO_DV_DONE
	} sdio_div_state_t;
endpackage : sdio_pkg

/* File: tb/sdio_core_model.sv */
`timescale 1ns/10ps
module sdio_core_model #(
	parameter int HALF = 5
) (
	input wire logic pclk,
	input wire logic presetn,
	output logic     freq_wave_a,
	output logic     freq_wave_b
);
	int cnt;
	// Wave a has period 2*HALF, wave b twice that
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cnt <= 0;
		else
			cnt <= (cnt == 4 * HALF - 1) ? 0 : cnt + 1;
	end
	assign freq_wave_a = (cnt % (2 * HALF)) < HALF;
	assign freq_wave_b = cnt < 2 * HALF;
endmodule : sdio_core_model

/* File: tb/sdio_slot_io_chk.sv */
`timescale 1ns/10ps
module sdio_slot_io_chk (
	input wire logic               pclk,
	input wire logic               presetn,
	input wire logic               clk_en,
	input wire logic               psel,
	input wire logic               penable,
	input wire logic               pwrite,
	input wire logic [7:0]         paddr,
	input wire logic [31:0]        pwdata,
	input wire logic               pslverr,
	input wire logic               fault_present,
	input wire logic               drive_run,
	input wire logic               slot_output_a,
	input wire logic               slot_output_b,
	input wire logic signed [15:0] freq_input_a
);
	logic wr_seen;
	wire  wr = psel && penable && pwrite && clk_en;
	wire  fn = paddr == 8'h44 || paddr == 8'h54;
	// Reset codes are only checked until software writes anything
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			wr_seen <= 1'b0;
		else if (wr)
			wr_seen <= 1'b1;
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_out_a_default: assert property (!(wr || wr_seen) && clk_en && $past(presetn)
		|=> slot_output_a == !$past(fault_present)) else $error("output a not no-fault");
	a_out_b_default: assert property (!(wr || wr_seen) && clk_en && $past(presetn)
		|=> slot_output_b == $past(drive_run)) else $error("output b not run");
	a_freq_sat: assert property (freq_input_a >= -16'sd10000 && freq_input_a <= 16'sd10000)
		else $error("scaled value out of range");
	a_func_refuse: assert property (wr && fn && pwdata > 32'h1e |-> pslverr)
		else $error("bad function code accepted");
	a_func_accept: assert property (wr && fn && pwdata <= 32'h1e |-> !pslverr)
		else $error("good function code refused");
	a_gain_refuse: assert property (wr && paddr[4:0] == 5'h0c && paddr < 8'h40
		&& pwdata > 32'h270f |-> pslverr) else $error("bad gain accepted");
	a_scale_refuse: assert property (wr && paddr < 8'h40 && paddr[4:0] inside {5'h04, 5'h08}
		&& pwdata > 32'h7d00 |-> pslverr) else $error("bad scale frequency accepted");
	a_ofs_refuse: assert property (wr && paddr < 8'h40 && paddr[4:0] == 5'h10
		&& ($signed(pwdata) > 10000 || $signed(pwdata) < -10000) |-> pslverr)
		else $error("bad offset accepted");
	c_func_write: cover property (wr && fn);
	c_refused: cover property (wr && pslverr);
	c_out_a_high: cover property (slot_output_a);
endmodule : sdio_slot_io_chk
bind sdio_slot_io sdio_slot_io_chk sdio_slot_io_chk_i (.*);

/* File: tb/sdio_slot_io_tb_top.sv */
`timescale 1ns/10ps
module sdio_slot_io_tb_top;
	logic pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0, err, pready;
	logic pslverr, pin_a = 0, wav = 0, slot_input_a_level, slot_input_b_level;
	logic slot_output_a, slot_output_b, freq_wave_a, freq_wave_b, pw;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd, x = 60, enabled_hours = 0, th [6];
	logic signed [15:0] freq_input_a, freq_input_b, speed_ref = 0, motor_speed = 0, motor_torque = 0;
	logic [15:0] motor_freq = 0, output_current = 0;
	logic [1:0] cmd_source = 0;
	logic [11:0] st = 0;
	wire logic drive_run, drive_ready, safe_torque_off_state, fault_present, alarm_present;
	wire logic net_cmd_a, net_cmd_b, plc_cmd_a, plc_cmd_b, forward_dir, ride_through_active;
	wire logic precharge_ok;
	// Pins follow the core's waves while frequency inputs are measured
	wire logic slot_input_a = wav ? freq_wave_a : pin_a;
	wire logic slot_input_b = wav & freq_wave_b;
	int fails = 0, compares = 0;
	logic [7:0] ra [6] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h44, 8'h54};
	logic [31:0] rv [6] = '{0, 32000, 1000, 0, 22, 19};
	assign {drive_run, drive_ready, safe_torque_off_state, fault_present, alarm_present, net_cmd_a,
		net_cmd_b, plc_cmd_a, plc_cmd_b, forward_dir, ride_through_active, precharge_ok} = st;
	sdio_slot_io #(.GATE_CYCLES(1000)) sdio_slot_io_i (.*);
	sdio_core_model #(.HALF(5)) sdio_core_model_i (.*);
	always #2 pclk = ~pclk;
	function automatic logic [31:0] rnd();
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		x = x ^ (x << 5);
		return x;
	endfunction : rnd
	function automatic int exp_scaled(int f, int lo, int hi, int g, int o);
		int p;
		f = f < lo ? lo : (f > hi ? hi : f);
		p = hi > lo ? (f - lo) * 10000 / (hi - lo) : 0;
		p = p * g / 1000 + o;
		return p > 10000 ? 10000 : (p < -10000 ? -10000 : p);
	endfunction : exp_scaled
	function automatic logic exp_out(int c);
		case (c)
			1: return 1'b1;
			2: return speed_ref > $signed(th[0][15:0]);
			3: return motor_speed > $signed(th[0][15:0]);
			4: return motor_speed < $signed(th[1][15:0]);
			5: return motor_speed == speed_ref;
			8: return motor_freq > th[2][15:0];
			9: return output_current > th[3][15:0];
			10: return output_current < th[3][15:0];
			11: return motor_torque > $signed(th[4][15:0]);
			12: return motor_torque < $signed(th[4][15:0]);
			13: return enabled_hours > th[5];
			16, 17, 18: return cmd_source == 2'(c - 16);
			19, 20, 21: return st[30 - c];
			22, 23: return st[8] == (c == 23);
			24: return !alarm_present;
			25: return !fault_present && !alarm_present;
			26: return net_cmd_a;
			27: return plc_cmd_a;
			28, 29, 30: return st[30 - c];
			default: return 1'b0;
		endcase
	endfunction : exp_out
	task automatic give_verdict();
		if (fails == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : give_verdict
	task automatic chk(string n, logic [31:0] e, logic [31:0] v);
		compares++;
		if (v !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", n, e, v);
		end
	endtask : chk
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
		int n;
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n < 10; n++) begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		if (n == 10) begin
			chk("pready", 1, 0);
			give_verdict();
		end
		{rd, err} = {prdata, pslverr};
		{psel, penable} <= 2'b00;
	endtask : apb
	task automatic rdchk(logic [7:0] a, logic [31:0] e);
		apb(1'b0, a, 0);
		chk("read", e, rd);
	endtask : rdchk
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		foreach (ra[i]) rdchk(ra[i], rv[i]);
		foreach (ra[i]) begin
			apb(1'b1, ra[i], i == 3 ? 10001 : (i == 2 ? 10000 : (i < 2 ? 32001 : 31)));
			chk("refused", 1, err);
		end
		foreach (ra[i]) rdchk(ra[i], rv[i]);
		for (int i = 0; i < 6; i++) begin
			th[i] = rnd();
			if (i != 5) th[i] = (i == 2 || i == 3) ? {16'h0, x[15:0]} : {{16{x[15]}}, x[15:0]};
			apb(1'b1, 8'h60 + 8'(4 * i), th[i]);
		end
		// Sweep every function code 0..30 on output a against random drive status
		for (int c = 0; c <= 30; c++) begin
			apb(1'b1, 8'h44, c);
			chk("accepted", 0, err);
			repeat (4) begin
				@(posedge pclk);
				{motor_torque, motor_freq} <= rnd();
				{output_current, speed_ref} <= rnd();
				{motor_speed, cmd_source, st} <= {x[31] ? x[15:0] : x[31:16], x[17:16], x[29:18]};
				enabled_hours <= x[20] ? th[5] + 1 : th[5] - {31'h0, x[21]};
				@(posedge pclk);
				#1 chk("out_a", exp_out(c), slot_output_a);
			end
		end
		apb(1'b1, 8'h00, 2);
		apb(1'b1, 8'h08, 2000);
		apb(1'b1, 8'h0c, 1500);
		apb(1'b1, 8'h10, -1000);
		apb(1'b1, 8'h20, 3);
		wav <= 1'b1;
		repeat (2100) @(posedge pclk);
		rdchk(8'h14, 1000);
		rdchk(8'h34, 500);
		chk("fi_a", exp_scaled(1000, 0, 2000, 1500, -1000), freq_input_a);
		rdchk(8'h18, exp_scaled(1000, 0, 2000, 1500, -1000));
		chk("fi_b", 0, freq_input_b);
		chk("lvl_b", 0, slot_input_b_level);
		apb(1'b1, 8'h0c, 9999);
		repeat (200) @(posedge pclk);
		chk("fi_sat", exp_scaled(1000, 0, 2000, 9999, -1000), freq_input_a);
		apb(1'b1, 8'h00, 0);
		{wav, pin_a} <= 2'b01;
		repeat (200) @(posedge pclk);
		chk("lvl_a", 1, slot_input_a_level);
		chk("fi_a0", 0, freq_input_a);
		apb(1'b1, 8'h50, 1);
		@(posedge pclk);
		repeat (40) begin
			#1 pw = freq_wave_b;
			@(posedge pclk);
			#1 chk("out_b", pw, slot_output_b);
		end
		give_verdict();
	end
endmodule : sdio_slot_io_tb_top
